/* File: sfpc_pkg.sv */
// constants for the serial flash protect control block
// What this block does
// - modes 0 and 3; sample on rising edge, drive out from falling edge
// - page write carries 1 to 256 bytes inside one page
// - block or full wipe starts a tracked internal erase cycle
// - program, erase, status store refused unless write latch set
// - write latch clears on power-up, latch clear, and modify completion
// - readable flag shows a status, program or erase cycle running
// - modifying commands need a clock count that is a multiple of eight
// - after deselect stay active until the running cycle ends
// - sleep command enters deep power-down until wake command
// - deep power-down ignores status store, program and erase
// - three protect level bits pick a top region of 0 to 64 sectors
// - page write or block wipe inside protected region is not executed
// - full wipe accepted only with all protect level bits zero
// - protect pin low with lock bit set freezes protect level and lock bits
// - boost level on its own boost_voltage_level pin selects fast program/erase mode
// - modifying commands blocked until power-up write delay expires
// - serial output driven only while selected, released otherwise
// - all bytes shift most significant bit first
// - sequences open with a command byte: 06h, 04h, 05h, 01h
package sfpc_pkg;
    localparam logic [7:0]  CMD_LATCH_SET    = 8'h06;
    localparam logic [7:0]  CMD_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0]  CMD_STATUS_READ  = 8'h05;
    localparam logic [7:0]  CMD_STATUS_STORE = 8'h01;
    localparam int          CNT_W            = 12;
    localparam int          ADDR_W           = 24;
    localparam int          TMR_W            = 24;
    localparam logic [11:0] CMD_BITS         = 12'h008;
    localparam logic [11:0] STORE_BITS       = 12'h010;
    localparam logic [11:0] HDR_BITS         = 12'h020;
    localparam logic [11:0] PAGE_MIN_BITS    = 12'h028;
    localparam logic [11:0] STORE_AT         = 12'h00F;
    localparam logic [11:0] ADDR_AT          = 12'h01F;
    localparam logic [11:0] CMD_AT           = 12'h007;
    localparam logic [8:0]  PAGE_BYTES       = 9'h100;
    localparam logic [6:0]  SECTOR_TOTAL     = 7'h40;
    localparam int          SECTOR_HI        = 21;
    localparam int          SECTOR_LO        = 16;
    localparam int          SR_ACTIVE        = 0;
    localparam int          SR_LATCH         = 1;
    localparam int          SR_LEVEL_LO      = 2;
    localparam int          SR_LOCK          = 7;
    localparam logic [2:0]  LEVEL_RESET      = 3'h0;
    localparam logic        LOCK_RESET       = 1'b0;
    localparam int          CLK_MHZ          = 100;
    localparam int          PUW_NS           = 10000;
    localparam int          PUW_CYC          = (PUW_NS * CLK_MHZ + 999) / 1000;
    localparam int          STORE_CYC        = 2000;
    localparam int          PAGE_CYC         = 6000;
    localparam int          BLOCK_CYC        = 60000;
    localparam int          FULL_CYC         = 600000;
    localparam int          FAST_SHIFT       = 1;

    typedef enum logic [1:0] {
        PWR_STANDBY,
        PWR_ACTIVE,
        PWR_DEEP
    } sfpc_pwr_e;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_SET,
        OP_CLEAR,
        OP_STORE,
        OP_PAGE,
        OP_BLOCK,
        OP_FULL,
        OP_SLEEP,
        OP_WAKE
    } sfpc_op_e;
endpackage : sfpc_pkg

/* File: sfpc_link_if.sv */
// frame words between the serial clock side and the core
`timescale 1ns/1ns
interface sfpc_link_if;
    import sfpc_pkg::*;
    logic [CNT_W-1:0]  bits;
    logic [7:0]        cmd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic [7:0]        sr;
    modport link (output bits, cmd, addr, data, input sr);
    modport core (input bits, cmd, addr, data, output sr);
endinterface : sfpc_link_if

/* File: sfpc_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ns
module sfpc_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q_ff
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= INIT;
            q_ff    <= INIT;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end
endmodule : sfpc_sync

/* File: sfpc_link_rx.sv */
// serial clock side: shifter, bit counter and output driver
`timescale 1ns/1ns
module sfpc_link_rx #(
    parameter logic [7:0] WAKE_CMD  = 8'hAB,
    parameter logic [7:0] SIGNATURE = 8'h5A
) (
    input  wire logic sclk,
    input  wire logic rst,
    input  wire logic cs_n,
    input  wire logic mosi,
    sfpc_link_if.link lk,
    output logic      dout_ff,
    output logic      dout_oe_n_ff
);
    import sfpc_pkg::*;

    logic        fresh_ff;
    logic [31:0] shift_ff;
    logic [7:0]  sr_sync;
    logic [2:0]  bit_idx;
    logic        read_sr;
    logic        read_sig;

    ////////////////////////////////////////////////////////////////////////
    // frame start marker; the clock may stand still while deselected
    always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
        if (rst) begin
            fresh_ff <= 1'b1;
        end else if (cs_n) begin
            fresh_ff <= 1'b1;
        end else begin
            fresh_ff <= 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            lk.bits <= '0;
        end else if (fresh_ff) begin
            lk.bits <= 12'h001;
        end else if (lk.bits != '1) begin
            lk.bits <= lk.bits + 12'h001;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            shift_ff <= '0;
            lk.cmd   <= '0;
            lk.addr  <= '0;
            lk.data  <= '0;
        end else begin
            shift_ff <= {shift_ff[30:0], mosi};
            if (!fresh_ff && lk.bits == CMD_AT) begin
                lk.cmd <= {shift_ff[6:0], mosi};
            end
            if (!fresh_ff && lk.bits == STORE_AT) begin
                lk.data <= {shift_ff[6:0], mosi};
            end
            if (!fresh_ff && lk.bits == ADDR_AT) begin
                lk.addr <= {shift_ff[22:0], mosi};
            end
        end
    end

    sfpc_sync #(.W(8), .INIT(8'h00)) u_sr_sync (
        .clk  (sclk),
        .rst  (rst),
        .d    (lk.sr),
        .q_ff (sr_sync)
    );

    assign bit_idx  = 3'(3'h7 - lk.bits[2:0]);
    assign read_sr  = lk.bits >= CMD_BITS && lk.cmd == CMD_STATUS_READ;
    assign read_sig = lk.bits >= HDR_BITS && lk.cmd == WAKE_CMD;

    ////////////////////////////////////////////////////////////////////////
    // drive only while selected
    always_ff @(negedge sclk or posedge rst or posedge cs_n) begin
        if (rst) begin
            dout_ff      <= 1'b0;
            dout_oe_n_ff <= 1'b1;
        end else if (cs_n) begin
            dout_ff      <= 1'b0;
            dout_oe_n_ff <= 1'b1;
        end else if (!fresh_ff && read_sr) begin
            dout_ff      <= sr_sync[bit_idx];
            dout_oe_n_ff <= 1'b0;
        end else if (!fresh_ff && read_sig) begin
            dout_ff      <= SIGNATURE[bit_idx];
            dout_oe_n_ff <= 1'b0;
        end
    end
endmodule : sfpc_link_rx

/* File: sfpc_top.sv */
// command acceptance, write protection and power state of the flash
`timescale 1ns/1ns
module sfpc_top #(
    parameter logic [7:0]       PAGE_CMD  = 8'h02,
    parameter logic [7:0]       BLOCK_CMD = 8'hD8,
    parameter logic [7:0]       FULL_CMD  = 8'hC7,
    parameter logic [7:0]       SLEEP_CMD = 8'hB9,
    parameter logic [7:0]       WAKE_CMD  = 8'hAB,
    // arbitrary value
    parameter logic [7:0]       SIGNATURE = 8'h5A,
    parameter int               PUW_CYC   = sfpc_pkg::PUW_CYC,
    parameter int               STORE_CYC = sfpc_pkg::STORE_CYC,
    parameter int               PAGE_CYC  = sfpc_pkg::PAGE_CYC,
    parameter int               BLOCK_CYC = sfpc_pkg::BLOCK_CYC,
    parameter int               FULL_CYC  = sfpc_pkg::FULL_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        sclk,
    input  wire logic                        cs_n,
    input  wire logic                        mosi,
    input  wire logic                        protect_n,
    input  wire logic                        boost_voltage_level,
    output logic                             data_out,
    output logic                             data_out_oe_n,
    output logic [7:0]                       status_ff,
    output logic                             cycle_active_flag_ff,
    output logic                             fast_mode_ff,
    output sfpc_pkg::sfpc_pwr_e              pwr_ff,
    output logic                             write_ready_ff,
    output logic                             soft_protect_state_ff,
    output logic                             hard_protect_state_ff,
    output logic                             op_start_ff,
    output sfpc_pkg::sfpc_op_e               op_kind_ff,
    output logic [sfpc_pkg::ADDR_W-1:0]      op_addr_ff,
    output logic [8:0]                       op_bytes_ff
);
    import sfpc_pkg::*;

    sfpc_link_if lk ();

    logic              cs_n_s;
    logic              protect_n_s;
    logic              boost_s;
    logic              cs_prev_ff;
    logic              frame_end;
    logic              write_latch_flag_ff;
    logic [2:0]        protect_level_ff;
    logic              status_lock_bit_ff;
    logic [TMR_W-1:0]  cyc_cnt_ff;
    logic [TMR_W-1:0]  pu_cnt_ff;
    logic [TMR_W-1:0]  cyc_len;
    sfpc_op_e          nxt_op;
    logic              aligned;
    logic              may_write;
    logic              locked;
    logic              start;
    logic              cycle_done;
    logic [5:0]        sector;
    logic [CNT_W-1:0]  data_bits;
    logic [8:0]        nxt_bytes;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // top region selected by protect level
    function automatic logic prot_hit(input logic [2:0] level,
                                      input logic [5:0] sec);
        logic [6:0] limit;
        limit = 7'h00;
        if (level == 3'h0) begin
            prot_hit = 1'b0;
        end else begin
            limit    = 7'(SECTOR_TOTAL - (7'h01 << (level - 3'h1)));
            prot_hit = {1'b0, sec} >= limit;
        end
    endfunction : prot_hit

    function automatic logic is_wipe_or_page(input sfpc_op_e op);
        is_wipe_or_page = op == OP_PAGE || op == OP_BLOCK || op == OP_FULL;
    endfunction : is_wipe_or_page

    ////////////////////////////////////////////////////////////////////////
    // serial clock side

    sfpc_link_rx #(
        .WAKE_CMD  (WAKE_CMD),
        .SIGNATURE (SIGNATURE)
    ) u_link (
        .sclk         (sclk),
        .rst          (rst),
        .cs_n         (cs_n),
        .mosi         (mosi),
        .lk           (lk.link),
        .dout_ff      (data_out),
        .dout_oe_n_ff (data_out_oe_n)
    );

    assign lk.sr = status_ff;

    ////////////////////////////////////////////////////////////////////////
    // pins into the core clock

    sfpc_sync #(.W(3), .INIT(3'b110)) u_pin_sync (
        .clk  (clk),
        .rst  (rst),
        .d    ({cs_n, protect_n, boost_voltage_level}),
        .q_ff ({cs_n_s, protect_n_s, boost_s})
    );

    // frame words are stable once the select is seen high: the serial
    // clock has stopped, so they are read here without a further crossing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_prev_ff <= 1'b1;
        end else begin
            cs_prev_ff <= cs_n_s;
        end
    end

    assign frame_end = cs_n_s && !cs_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // command decode at deselect

    assign aligned   = lk.bits[2:0] == 3'h0;
    assign sector    = lk.addr[SECTOR_HI:SECTOR_LO];
    assign locked    = status_lock_bit_ff && !protect_n_s;
    assign may_write = write_latch_flag_ff && write_ready_ff;
    assign data_bits = 12'(lk.bits - HDR_BITS);

    always_comb begin
        nxt_op = OP_NONE;
        if (frame_end && lk.bits >= CMD_BITS) begin
            if (pwr_ff == PWR_DEEP) begin
                // only the wake command leaves sleep
                if (lk.cmd == WAKE_CMD) begin
                    nxt_op = OP_WAKE;
                end
            end else if (!cycle_active_flag_ff && aligned) begin
                case (lk.cmd)
                    CMD_LATCH_SET: begin
                        if (lk.bits == CMD_BITS) begin
                            nxt_op = OP_SET;
                        end
                    end
                    CMD_LATCH_CLEAR: begin
                        if (lk.bits == CMD_BITS) begin
                            nxt_op = OP_CLEAR;
                        end
                    end
                    CMD_STATUS_STORE: begin
                        if (may_write && lk.bits >= STORE_BITS && !locked) begin
                            nxt_op = OP_STORE;
                        end
                    end
                    PAGE_CMD: begin
                        // no page write in protected region
                        if (may_write && lk.bits >= PAGE_MIN_BITS &&
                            !prot_hit(protect_level_ff, sector)) begin
                            nxt_op = OP_PAGE;
                        end
                    end
                    BLOCK_CMD: begin
                        // no block wipe in protected region
                        if (may_write && lk.bits == HDR_BITS &&
                            !prot_hit(protect_level_ff, sector)) begin
                            nxt_op = OP_BLOCK;
                        end
                    end
                    FULL_CMD: begin
                        if (may_write && lk.bits == CMD_BITS &&
                            protect_level_ff == 3'h0) begin
                            nxt_op = OP_FULL;
                        end
                    end
                    SLEEP_CMD: begin
                        if (lk.bits == CMD_BITS) begin
                            nxt_op = OP_SLEEP;
                        end
                    end
                    default: begin
                        nxt_op = OP_NONE;
                    end
                endcase
            end
        end
    end

    assign start = nxt_op == OP_STORE || is_wipe_or_page(nxt_op);

    // page data capped at one page
    always_comb begin
        nxt_bytes = 9'h000;
        if (nxt_op == OP_PAGE) begin
            if (data_bits[CNT_W-1:3] > 9'(PAGE_BYTES)) begin
                nxt_bytes = PAGE_BYTES;
            end else begin
                nxt_bytes = 9'(data_bits[CNT_W-1:3]);
            end
        end
    end

    always_comb begin
        case (nxt_op)
            OP_STORE: cyc_len = TMR_W'(STORE_CYC);
            OP_PAGE:  cyc_len = TMR_W'(PAGE_CYC);
            OP_BLOCK: cyc_len = TMR_W'(BLOCK_CYC);
            OP_FULL:  cyc_len = TMR_W'(FULL_CYC);
            default:  cyc_len = TMR_W'(1);
        endcase
        if (boost_s && is_wipe_or_page(nxt_op)) begin
            cyc_len = cyc_len >> FAST_SHIFT;
        end
        if (cyc_len == '0) begin
            cyc_len = TMR_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal cycle timer

    assign cycle_done = cycle_active_flag_ff && cyc_cnt_ff == TMR_W'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_cnt_ff <= '0;
        end else if (start) begin
            cyc_cnt_ff <= cyc_len;
        end else if (cyc_cnt_ff != '0) begin
            cyc_cnt_ff <= cyc_cnt_ff - TMR_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cycle_active_flag_ff <= 1'b0;
        end else if (start) begin
            cycle_active_flag_ff <= 1'b1;
        end else if (cycle_done) begin
            cycle_active_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fast_mode_ff <= 1'b0;
        end else if (start) begin
            fast_mode_ff <= boost_s && is_wipe_or_page(nxt_op);
        end else if (cycle_done) begin
            fast_mode_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-up write delay

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pu_cnt_ff      <= TMR_W'(PUW_CYC);
            write_ready_ff <= 1'b0;
        end else if (pu_cnt_ff != '0) begin
            pu_cnt_ff      <= pu_cnt_ff - TMR_W'(1);
            write_ready_ff <= 1'b0;
        end else begin
            write_ready_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status bits

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_latch_flag_ff <= 1'b0;
        end else if (nxt_op == OP_SET) begin
            write_latch_flag_ff <= 1'b1;
        end else if (nxt_op == OP_CLEAR || cycle_done) begin
            write_latch_flag_ff <= 1'b0;
        end
    end

    // only an accepted store alters these
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            protect_level_ff   <= LEVEL_RESET;
            status_lock_bit_ff <= LOCK_RESET;
        end else if (nxt_op == OP_STORE) begin
            protect_level_ff   <= lk.data[SR_LEVEL_LO+2:SR_LEVEL_LO];
            status_lock_bit_ff <= lk.data[SR_LOCK];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= '0;
        end else begin
            status_ff                           <= '0;
            status_ff[SR_ACTIVE]                <= cycle_active_flag_ff;
            status_ff[SR_LATCH]                 <= write_latch_flag_ff;
            status_ff[SR_LEVEL_LO+2:SR_LEVEL_LO] <= protect_level_ff;
            status_ff[SR_LOCK]                  <= status_lock_bit_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soft_protect_state_ff <= 1'b0;
            hard_protect_state_ff <= 1'b0;
        end else begin
            soft_protect_state_ff <= protect_level_ff != 3'h0;
            hard_protect_state_ff <= locked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power state

    // active while selected or busy; deep sleep gate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_ff <= PWR_STANDBY;
        end else begin
            case (pwr_ff)
                PWR_DEEP: begin
                    if (nxt_op == OP_WAKE) begin
                        pwr_ff <= PWR_ACTIVE;
                    end
                end
                PWR_STANDBY, PWR_ACTIVE: begin
                    if (nxt_op == OP_SLEEP) begin
                        pwr_ff <= PWR_DEEP;
                    end else if (!cs_n_s || cycle_active_flag_ff || start) begin
                        pwr_ff <= PWR_ACTIVE;
                    end else begin
                        pwr_ff <= PWR_STANDBY;
                    end
                end
                default: begin
                    pwr_ff <= PWR_STANDBY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operation request to the array

    // header and page byte count handed to the array
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_start_ff <= 1'b0;
            op_kind_ff  <= OP_NONE;
            op_addr_ff  <= '0;
            op_bytes_ff <= '0;
        end else begin
            op_start_ff <= start;
            if (start) begin
                op_kind_ff  <= nxt_op;
                op_addr_ff  <= lk.addr;
                op_bytes_ff <= nxt_bytes;
            end
        end
    end
endmodule : sfpc_top

/* File: sfpc_chk.sv */
// port assertions for sfpc_top
`timescale 1ns/1ns
module sfpc_chk (
    input logic                clk,
    input logic                rst,
    input logic                cs_n,
    input logic                data_out_oe_n,
    input logic [7:0]          status_ff,
    input logic                cycle_active_flag_ff,
    input logic                write_ready_ff,
    input logic                hard_protect_state_ff,
    input logic                op_start_ff,
    input sfpc_pkg::sfpc_pwr_e pwr_ff,
    input sfpc_pkg::sfpc_op_e  op_kind_ff
);
    import sfpc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_oe; cs_n |-> data_out_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("out driven idle");
    property p_rdy; op_start_ff |-> write_ready_ff; endproperty
    a_rdy: assert property (p_rdy) else $error("start too early");
    property p_cyc; op_start_ff |-> cycle_active_flag_ff; endproperty
    a_cyc: assert property (p_cyc) else $error("no busy flag");
    property p_full;
        op_start_ff && op_kind_ff == OP_FULL |-> status_ff[4:2] == 3'h0;
    endproperty
    a_full: assert property (p_full) else $error("wipe protected");
    property p_wel; $fell(cycle_active_flag_ff) |=> !status_ff[1]; endproperty
    a_wel: assert property (p_wel) else $error("latch kept");
    property p_pwr; cycle_active_flag_ff |-> pwr_ff != PWR_STANDBY; endproperty
    a_pwr: assert property (p_pwr) else $error("standby early");
    property p_deep; pwr_ff == PWR_DEEP |-> !op_start_ff; endproperty
    a_deep: assert property (p_deep) else $error("op in sleep");
    property p_lock;
        op_start_ff && op_kind_ff == OP_STORE |-> !hard_protect_state_ff;
    endproperty
    a_lock: assert property (p_lock) else $error("store locked");
endmodule : sfpc_chk
bind sfpc_top sfpc_chk i_sfpc_chk (.*);

/* File: sfpc_master.sv */
// serial bus master model for the link
`timescale 1ns/1ns
module sfpc_master (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input  logic data_out,
    input  logic data_out_oe_n
);
    logic last_ff;
    logic miso;
    initial begin
        sclk = 0; cs_n = 1; mosi = 0; last_ff = 0;
    end
    // released line shows inverse, no pull resistor
    always @(data_out or data_out_oe_n) if (!data_out_oe_n) last_ff = data_out;
    assign miso = data_out_oe_n ? ~last_ff : data_out;
    task automatic frame(input logic [47:0] v, input int n, input bit m3,
                         output logic [7:0] rd);
        sclk = m3;
        #8 cs_n = 0;
        for (int i = n - 1; i >= 0; i--) begin
            #8 sclk = 0;
            mosi = v[i];
            #7 sclk = 1;
            rd = {rd[6:0], miso};
        end
        #8 sclk = m3;
        #4 cs_n = 1;
    endtask : frame
endmodule : sfpc_master

/* File: sfpc_top_tb.sv */
// self-checking bench for sfpc_top
`timescale 1ns/1ns
module sfpc_top_tb;
    import sfpc_pkg::*;
    logic        clk = 0, rst = 1, protect_n = 1, boost_voltage_level = 0;
    logic        sclk, cs_n, mosi, data_out, data_out_oe_n, op_start_ff;
    logic        cycle_active_flag_ff, fast_mode_ff, write_ready_ff;
    logic        soft_protect_state_ff, hard_protect_state_ff;
    logic [7:0]  status_ff, rd;
    logic [23:0] op_addr_ff;
    logic [8:0]  op_bytes_ff;
    sfpc_pwr_e   pwr_ff;
    sfpc_op_e    op_kind_ff;
    int          n_errors = 0, samples_checked = 0, n_ops = 0;
    // long cycles shortened, still outlast a status poll
    sfpc_top #(.PUW_CYC(20), .STORE_CYC(200), .PAGE_CYC(200),
        .BLOCK_CYC(200), .FULL_CYC(200)) i_sfpc_top (.*);
    sfpc_master i_sfpc_master (.*);
    always #5 clk = ~clk;
    always @(posedge clk) if (op_start_ff === 1'b1) n_ops <= n_ops + 1;
    task automatic chk(input logic [47:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic go(input logic [47:0] v, input int n, input bit m3, e);
        int n0;
        n0 = n_ops;
        i_sfpc_master.frame(v, n, m3, rd);
        repeat (8) @(posedge clk);
        chk(n_ops - n0, e);
    endtask : go
    task automatic sr(input logic [7:0] exp);
        go({CMD_STATUS_READ, 8'h00}, 16, 1, 0);
        chk(rd, exp);
    endtask : sr
    task automatic fin;
        for (int i = 0; i < 1000 && cycle_active_flag_ff !== 1'b0; i++)
            @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : fin
    task automatic t_guard;
        repeat (19) @(posedge clk);
        #1 chk(write_ready_ff, 0);
        repeat (4) @(posedge clk);
        #1 chk(write_ready_ff, 1);
    endtask : t_guard
    task automatic t_latch;
        go({8'h02, 24'h000100, 8'hA5}, 40, 0, 0);
        go(CMD_LATCH_SET, 8, 0, 0);
        sr(8'h02);
        go({8'h02, 24'h000100, 8'hA5}, 41, 0, 0);
        go(CMD_LATCH_CLEAR, 8, 1, 0);
        sr(8'h00);
    endtask : t_latch
    task automatic t_page;
        go(CMD_LATCH_SET, 8, 1, 0);
        go({8'h02, 24'h01FF00, 16'hA55A}, 48, 1, 1);
        chk({op_kind_ff, op_bytes_ff, op_addr_ff}, {OP_PAGE, 9'h2, 24'h01FF00});
        sr(8'h03);
        fin;
        sr(8'h00);
    endtask : t_page
    task automatic t_protect;
        go(CMD_LATCH_SET, 8, 0, 0);
        go({CMD_STATUS_STORE, 8'h98}, 16, 0, 1);
        fin;
        sr(8'h98);
        chk(soft_protect_state_ff, 1);
        go(CMD_LATCH_SET, 8, 0, 0);
        go({8'h02, 24'h200000, 8'h00}, 40, 0, 0);
        go(8'hC7, 8, 0, 0);
        go({8'hD8, 24'h1FFFFF}, 32, 0, 1);
        chk(op_kind_ff, OP_BLOCK);
        fin;
        @(posedge clk) protect_n <= 0;
        go(CMD_LATCH_SET, 8, 0, 0);
        go({CMD_STATUS_STORE, 8'h00}, 16, 0, 0);
        chk(hard_protect_state_ff, 1);
        sr(8'h9A);
        @(posedge clk) protect_n <= 1;
        go({CMD_STATUS_STORE, 8'h00}, 16, 0, 1);
        fin;
    endtask : t_protect
    task automatic t_power;
        go(CMD_LATCH_SET, 8, 1, 0);
        @(posedge clk) boost_voltage_level <= 1;
        go(8'hC7, 8, 1, 1);
        chk(fast_mode_ff, 1);
        fin;
        @(posedge clk) boost_voltage_level <= 0;
        // latch held, so only sleep can refuse the store
        go(CMD_LATCH_SET, 8, 0, 0);
        go(8'hB9, 8, 0, 0);
        chk(pwr_ff, PWR_DEEP);
        go(CMD_LATCH_SET, 8, 0, 0);
        go({CMD_STATUS_STORE, 8'h00}, 16, 0, 0);
        go({8'hAB, 32'h0}, 40, 0, 0);
        chk(rd, 8'h5A);
        chk(pwr_ff != PWR_DEEP, 1);
    endtask : t_power
    task automatic conclude;
        if (n_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        t_guard;
        t_latch;
        t_page;
        t_protect;
        t_power;
        conclude;
    end
    initial begin
        #900000;
        n_errors++;
        conclude;
    end
endmodule : sfpc_top_tb
